// ### ehp_cfg.svh
`ifndef EHP_CFG_SVH
`define EHP_CFG_SVH
// ----------------------------------------
// clock and timing
// ----------------------------------------
`define EHP_CLK_PERIOD_NS 4
`define EHP_RST_MIN_NS    100
`define EHP_RST_CYC       ((`EHP_RST_MIN_NS + `EHP_CLK_PERIOD_NS - 1) / `EHP_CLK_PERIOD_NS)
`define EHP_SETUP_CYC     2
`define EHP_STROBE_CYC    3
`define EHP_POR_CYC       16
// ----------------------------------------
// table geometry
// ----------------------------------------
`define EHP_TBL_FIRST     1
`define EHP_WT_DEPTH      15
`define EHP_RT_DEPTH      23
// ----------------------------------------
// write table reset values
// ----------------------------------------
`define EHP_WT_CFG2_ADDR  2
`define EHP_WT_CFG2_RST   8'h40
`define EHP_WT_CFG3_ADDR  3
`define EHP_WT_CFG3_RST   8'h44
`define EHP_WT_SENS9_ADDR 9
`define EHP_WT_SENS9_RST  8'h01
`define EHP_WT_CTL15_ADDR 15
`define EHP_WT_CTL15_RST  8'h18
`define EHP_WT_OTHER_RST  8'h00
`define EHP_CLIP_BIT      7
`define EHP_IDLE_BUS      8'hFF
`endif

// ### ehp_pkg.sv
`default_nettype none
package ehp_pkg;
  typedef logic [7:0] ehp_byte_t;
  typedef logic [9:0] ehp_video_t;
  typedef enum logic [1:0] {
    EHP_CMD_ADDR = 2'h0,
    EHP_CMD_WR   = 2'h1,
    EHP_CMD_RD   = 2'h2
  } ehp_cmd_t;
  typedef enum logic [1:0] {
    EHP_ST_IDLE   = 2'h0,
    EHP_ST_SETUP  = 2'h1,
    EHP_ST_STROBE = 2'h3,
    EHP_ST_RECOV  = 2'h2
  } ehp_state_t;
endpackage : ehp_pkg
`default_nettype wire

// ### ehp_if.sv
`include "ehp_cfg.svh"
`default_nettype none
interface ehp_if;
  logic [7:0] p_bus;
  logic [7:0] p_host_out;
  logic       p_host_oe;
  logic [7:0] p_dev_out;
  logic       p_dev_oe;
  logic       cs_n;
  logic       rw;
  logic       ad;
  logic       host_port_select;
  logic       dev_reset_n;

  // pulled-up wire; device wins a contention so it stays visible
  assign p_bus = p_dev_oe ? p_dev_out : (p_host_oe ? p_host_out : `EHP_IDLE_BUS);

  modport dev (
    input  p_bus, cs_n, rw, ad, host_port_select, dev_reset_n,
    output p_dev_out, p_dev_oe
  );
  modport host (
    input  p_bus,
    output p_host_out, p_host_oe, cs_n, rw, ad, host_port_select, dev_reset_n
  );
endinterface : ehp_if
`default_nettype wire

// ### ehp_sync.sv
`default_nettype none
module ehp_sync #(
  parameter int               WIDTH   = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  generate
    if (WIDTH < 1)
    begin : g_chk
      $error("ehp_sync: WIDTH must be positive");
    end
  endgenerate

  // first stage is read by the second stage only
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : ehp_sync
`default_nettype wire

// ### ehp_device.sv
// Notes on behaviour
// - one 8-bit bus carries addresses and data
// - transfers timed only by host strobes
// - capture on chip select falling edge
// - drive bus only when reading and selected
// - address phase loads current table address
// - data write stores byte at current address
// - host releases bus before read phase
// - data read presents byte at current address
// - address advances after each data access
// - new address always replaces incremented one
// - host accesses only inside safe window
// - reads show last field, writes next
// - reset restores all table defaults
// - video keeps flowing, unprocessed, during reset
// - internal power-on reset initialises control
// - external reset held at least 100ns
// - parallel port active only when select low
// - write table 15 bytes, read 23
`include "ehp_cfg.svh"
`default_nettype none
module ehp_device #(
  parameter int WT_DEPTH = `EHP_WT_DEPTH,
  parameter int RT_DEPTH = `EHP_RT_DEPTH,
  parameter int POR_CYC  = `EHP_POR_CYC
) (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  // host port pins
  ehp_if.dev                          host_bus,
  // video path
  input  wire ehp_pkg::ehp_video_t    video_in,
  output ehp_pkg::ehp_video_t         video_out,
  // packet events from the core
  input  wire logic                   edh_pkt_exit,
  input  wire logic                   edh_pkt_insert,
  // table contents to and from the core
  input  wire logic [RT_DEPTH*8-1:0]  status_bytes,
  output logic      [WT_DEPTH*8-1:0]  config_bytes
);
  import ehp_pkg::*;

  localparam int POR_W = $clog2(POR_CYC + 1);
  localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYC - 1);
  localparam logic [7:0] WT_LAST = 8'(WT_DEPTH);
  localparam logic [7:0] RT_LAST = 8'(RT_DEPTH);
  localparam logic [7:0] TBL_FIRST = 8'(`EHP_TBL_FIRST);

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  generate
    if (WT_DEPTH < `EHP_WT_CTL15_ADDR || WT_DEPTH > 255 || RT_DEPTH < 1 || RT_DEPTH > 255 || POR_CYC < 1)
    begin : g_chk
      $error("ehp_device: table depth or reset count out of range");
    end
  endgenerate

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  function automatic ehp_byte_t wt_default(input int addr);
    ehp_byte_t v;
    v = `EHP_WT_OTHER_RST;
    case (addr)
      `EHP_WT_CFG2_ADDR:  v = `EHP_WT_CFG2_RST;
      `EHP_WT_CFG3_ADDR:  v = `EHP_WT_CFG3_RST;
      `EHP_WT_SENS9_ADDR: v = `EHP_WT_SENS9_RST;
      `EHP_WT_CTL15_ADDR: v = `EHP_WT_CTL15_RST;
      default:            v = `EHP_WT_OTHER_RST;
    endcase
    return v;
  endfunction : wt_default

  function automatic logic [WT_DEPTH*8-1:0] wt_default_vec();
    logic [WT_DEPTH*8-1:0] v;
    v = '0;
    for (int i = 0; i < WT_DEPTH; i++)
      v[i*8 +: 8] = wt_default(i + `EHP_TBL_FIRST);
    return v;
  endfunction : wt_default_vec

  localparam logic [WT_DEPTH*8-1:0] WT_RST_VEC = wt_default_vec();

  // ----------------------------------------
  // power-on and combined control reset
  // ----------------------------------------
  // power-up value only; reset_n alone does not restart this count
  logic [POR_W-1:0] por_cnt_reg  = '0;
  logic             por_done_reg = 1'b0;
  logic             ctl_rst_n;

  always_ff @(posedge ref_clk)
  begin
    if (!por_done_reg)
    begin
      por_cnt_reg <= por_cnt_reg + POR_W'(1);
      if (por_cnt_reg == POR_LAST)
        por_done_reg <= 1'b1;
    end
  end

  assign ctl_rst_n = reset_n & host_bus.dev_reset_n & por_done_reg;

  // ----------------------------------------
  // strobe detection
  // ----------------------------------------
  // pins are synchronous; a strobe is the sampled falling edge of chip select
  logic cs_q_reg;
  logic strobe;
  logic addr_wr;
  logic data_wr;
  logic data_rd;

  always_ff @(posedge ref_clk or negedge ctl_rst_n)
  begin
    if (!ctl_rst_n)
      cs_q_reg <= 1'b1;
    else
      cs_q_reg <= host_bus.cs_n;
  end

  assign strobe  = cs_q_reg & ~host_bus.cs_n & ~host_bus.host_port_select;
  assign addr_wr = strobe & ~host_bus.rw & host_bus.ad;
  assign data_wr = strobe & ~host_bus.rw & ~host_bus.ad;
  assign data_rd = strobe & host_bus.rw & ~host_bus.ad;

  // ----------------------------------------
  // current table address
  // ----------------------------------------
  ehp_byte_t addr_reg;

  always_ff @(posedge ref_clk or negedge ctl_rst_n)
  begin
    if (!ctl_rst_n)
      addr_reg <= TBL_FIRST;
    else if (addr_wr)
      addr_reg <= host_bus.p_bus;
    else if (data_wr || data_rd)
      addr_reg <= addr_reg + 8'h01;
  end

  // ----------------------------------------
  // write table: staged by host, applied at packet insertion
  // ----------------------------------------
  ehp_byte_t            wt_stage   [WT_DEPTH];
  logic [WT_DEPTH*8-1:0] wt_active;

  generate
    for (genvar i = 0; i < WT_DEPTH; i++)
    begin : g_wt
      always_ff @(posedge ref_clk or negedge ctl_rst_n)
      begin
        if (!ctl_rst_n)
          wt_stage[i] <= WT_RST_VEC[i*8 +: 8];
        else if (data_wr && addr_reg == 8'(i + `EHP_TBL_FIRST))
          wt_stage[i] <= host_bus.p_bus;
      end

      // writes made in the window reach the next packet, not the current one
      always_ff @(posedge ref_clk or negedge ctl_rst_n)
      begin
        if (!ctl_rst_n)
          wt_active[i*8 +: 8] <= WT_RST_VEC[i*8 +: 8];
        else if (edh_pkt_insert)
          wt_active[i*8 +: 8] <= wt_stage[i];
      end
    end
  endgenerate

  // ----------------------------------------
  // read table: snapshot of the packet that just left
  // ----------------------------------------
  ehp_byte_t rt_snap [RT_DEPTH];
  ehp_byte_t rd_byte;

  generate
    for (genvar j = 0; j < RT_DEPTH; j++)
    begin : g_rt
      always_ff @(posedge ref_clk or negedge ctl_rst_n)
      begin
        if (!ctl_rst_n)
          rt_snap[j] <= 8'h00;
        else if (edh_pkt_exit)
          rt_snap[j] <= status_bytes[j*8 +: 8];
      end
    end
  endgenerate

  // out-of-range addresses read as zero and writes there are dropped
  always_comb
  begin
    rd_byte = 8'h00;
    if (addr_reg >= TBL_FIRST && addr_reg <= RT_LAST)
      rd_byte = rt_snap[5'(addr_reg - TBL_FIRST)];
  end

  // ----------------------------------------
  // bus drive
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge ctl_rst_n)
  begin
    if (!ctl_rst_n)
      host_bus.p_dev_out <= 8'h00;
    else if (data_rd)
      host_bus.p_dev_out <= rd_byte;
  end

  // enable is combinational on the pins by design; data follows one cycle after the strobe
  assign host_bus.p_dev_oe = host_bus.rw & ~host_bus.cs_n & ~host_bus.host_port_select;

  // ----------------------------------------
  // crossing into the core
  // ----------------------------------------
  ehp_sync #(
    .WIDTH   (WT_DEPTH * 8),
    .RST_VAL (WT_RST_VEC)
  ) u_cfg_sync (
    .ref_clk (ref_clk),
    .reset_n (ctl_rst_n),
    .d       (wt_active),
    .q       (config_bytes)
  );

  // ----------------------------------------
  // video path
  // ----------------------------------------
  // no reset here: the pipe must keep moving while control is held in reset
  function automatic ehp_video_t clip_word(input ehp_video_t w, input logic en);
    ehp_video_t r;
    r = w;
    if (en && w <= 10'h003)
      r = 10'h004;
    else if (en && w >= 10'h3FC)
      r = 10'h3FB;
    return r;
  endfunction : clip_word

  logic clip_en;
  assign clip_en = config_bytes[(`EHP_WT_CFG3_ADDR - `EHP_TBL_FIRST) * 8 + `EHP_CLIP_BIT];

  // limitation: clipping applies to every word, not just active picture
  always_ff @(posedge ref_clk)
  begin
    video_out <= clip_word(video_in, clip_en);
  end

  logic unused_wt_last;
  assign unused_wt_last = ^WT_LAST;
endmodule : ehp_device
`default_nettype wire

// ### ehp_host.sv
`include "ehp_cfg.svh"
`default_nettype none
module ehp_host #(
  parameter int SETUP_CYC  = `EHP_SETUP_CYC,
  parameter int STROBE_CYC = `EHP_STROBE_CYC,
  parameter int RST_CYC    = `EHP_RST_CYC
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // host port pins
  ehp_if.host                    dev_bus,
  // user command side
  input  wire logic              access_safe,
  input  wire logic              cmd_valid,
  input  wire ehp_pkg::ehp_cmd_t cmd_kind,
  input  wire ehp_pkg::ehp_byte_t cmd_byte,
  output logic                   cmd_ready,
  output logic                   rsp_valid,
  output ehp_pkg::ehp_byte_t     rsp_byte
);
  import ehp_pkg::*;

  generate
    if (SETUP_CYC < 1 || SETUP_CYC > 15 || STROBE_CYC < 2 || STROBE_CYC > 15 || RST_CYC < 1 || RST_CYC > 255)
    begin : g_chk
      $error("ehp_host: timing counts out of range");
    end
  endgenerate

  ehp_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] rst_cnt_reg;
  logic       rst_done;
  logic       accept;

  assign rst_done = dev_bus.dev_reset_n;
  assign accept = cmd_valid & cmd_ready & access_safe;

  // ----------------------------------------
  // device reset pulse
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_cnt_reg         <= 8'h00;
      dev_bus.dev_reset_n <= 1'b0;
    end
    else if (!dev_bus.dev_reset_n)
    begin
      rst_cnt_reg <= rst_cnt_reg + 8'h01;
      if (rst_cnt_reg == 8'(RST_CYC - 1))
        dev_bus.dev_reset_n <= 1'b1;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= EHP_ST_IDLE;
      cnt_reg   <= 4'h0;
    end
    else
    begin
      unique case (state_reg)
        EHP_ST_IDLE:
          if (accept)
          begin
            state_reg <= EHP_ST_SETUP;
            cnt_reg   <= 4'(SETUP_CYC - 1);
          end
        EHP_ST_SETUP:
          if (cnt_reg == 4'h0)
          begin
            state_reg <= EHP_ST_STROBE;
            cnt_reg   <= 4'(STROBE_CYC - 1);
          end
          else
            cnt_reg <= cnt_reg - 4'h1;
        EHP_ST_STROBE:
          if (cnt_reg == 4'h0)
            state_reg <= EHP_ST_RECOV;
          else
            cnt_reg <= cnt_reg - 4'h1;
        EHP_ST_RECOV:
          state_reg <= EHP_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      cmd_ready <= 1'b0;
    else if (accept)
      cmd_ready <= 1'b0;
    else if (state_reg == EHP_ST_IDLE && rst_done)
      cmd_ready <= 1'b1;
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // bus and controls settle for SETUP_CYC before the strobe and hold through recovery
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dev_bus.rw         <= 1'b1;
      dev_bus.ad         <= 1'b0;
      dev_bus.p_host_oe  <= 1'b0;
      dev_bus.p_host_out <= 8'h00;
    end
    else if (accept)
    begin
      dev_bus.rw         <= (cmd_kind == EHP_CMD_RD);
      dev_bus.ad         <= (cmd_kind == EHP_CMD_ADDR);
      dev_bus.p_host_oe  <= (cmd_kind != EHP_CMD_RD);
      dev_bus.p_host_out <= cmd_byte;
    end
    else if (state_reg == EHP_ST_RECOV)
    begin
      dev_bus.p_host_oe <= 1'b0;
      dev_bus.rw        <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      dev_bus.cs_n <= 1'b1;
    else if (state_reg == EHP_ST_SETUP && cnt_reg == 4'h0)
      dev_bus.cs_n <= 1'b0;
    else if (state_reg == EHP_ST_STROBE && cnt_reg == 4'h0)
      dev_bus.cs_n <= 1'b1;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      dev_bus.host_port_select <= 1'b1;
    else
      dev_bus.host_port_select <= 1'b0;
  end

  // ----------------------------------------
  // read answer
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rsp_valid <= 1'b0;
      rsp_byte  <= 8'h00;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (state_reg == EHP_ST_STROBE && cnt_reg == 4'h0 && dev_bus.rw)
      begin
        rsp_valid <= 1'b1;
        rsp_byte  <= dev_bus.p_bus;
      end
    end
  end
endmodule : ehp_host
`default_nettype wire

// ### ehp_sva.sv
`include "ehp_cfg.svh"
`default_nettype none
module ehp_sva #(
  parameter int RST_CYC = `EHP_RST_CYC
) (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       reset_n,
  // pins
  input wire logic [7:0] p_bus,
  input wire logic [7:0] p_host_out,
  input wire logic       p_host_oe,
  input wire logic [7:0] p_dev_out,
  input wire logic       p_dev_oe,
  input wire logic       cs_n,
  input wire logic       rw,
  input wire logic       ad,
  input wire logic       host_port_select,
  input wire logic       dev_reset_n
);
  int low_cnt_reg;
  // ----------------------------------------
  // device reset width
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n || dev_reset_n)
      low_cnt_reg <= 0;
    else
      low_cnt_reg <= low_cnt_reg + 1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence strobe_s;
    $fell(cs_n) && !host_port_select;
  endsequence
  sequence hold_low_s;
    !cs_n [*3] ##1 cs_n;
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  oe_combo_a: assert property (p_dev_oe == (rw && !cs_n && !host_port_select))
    else $error("device drive enable wrong");
  bus_owner_a: assert property (p_dev_oe |-> p_bus == p_dev_out)
    else $error("bus not showing device byte");
  host_release_a: assert property ((rw && !cs_n) |-> !p_host_oe)
    else $error("host drives bus during read");
  write_drive_a: assert property ((!cs_n && !rw) |-> p_host_oe)
    else $error("host not driving bus on write");
  strobe_len_a: assert property (strobe_s |-> hold_low_s)
    else $error("strobe width wrong");
  strobe_stable_a: assert property ((!cs_n && !$past(cs_n)) |-> $stable(rw) && $stable(ad) && (rw || $stable(p_bus)))
    else $error("controls moved in strobe");
  strobe_gap_a: assert property ($rose(cs_n) |=> cs_n)
    else $error("no idle cycle between strobes");
  read_update_a: assert property (disable iff (!reset_n || !dev_reset_n)
    $changed(p_dev_out) |-> $past(cs_n, 2) && !$past(cs_n) && $past(rw) && !$past(ad) && !$past(host_port_select))
    else $error("read byte changed without read strobe");
  rst_width_a: assert property ($rose(dev_reset_n) |-> low_cnt_reg >= RST_CYC - 1)
    else $error("device reset pulse too short");
  read_seen_c: cover property (strobe_s ##0 (rw && !ad));
endmodule : ehp_sva
`default_nettype wire

// ### edh_parallel_host_port_bench.sv
`include "ehp_cfg.svh"
`default_nettype none
module edh_parallel_host_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ehp_pkg::*;
  localparam int CLIP_IDX = (`EHP_WT_CFG3_ADDR - 1) * 8 + `EHP_CLIP_BIT;
  logic         ref_clk, reset_n, access_safe, cmd_valid, cmd_ready, rsp_valid;
  logic         edh_pkt_exit, edh_pkt_insert, clip_d, clip_dd, vid_on;
  ehp_cmd_t     cmd_kind;
  ehp_byte_t    cmd_byte, rsp_byte, b;
  ehp_video_t   video_in, video_out, vin_d;
  logic [183:0] status_bytes, snap;
  logic [119:0] config_bytes, exp_cfg;
  ehp_byte_t    exp_q[$];
  int           miscompares, check_count;
  ehp_if bus_if();
  ehp_device ehp_device_inst (.ref_clk(ref_clk), .reset_n(reset_n), .host_bus(bus_if), .video_in(video_in),
    .video_out(video_out), .edh_pkt_exit(edh_pkt_exit), .edh_pkt_insert(edh_pkt_insert),
    .status_bytes(status_bytes), .config_bytes(config_bytes));
  ehp_host ehp_host_inst (.ref_clk(ref_clk), .reset_n(reset_n), .dev_bus(bus_if), .access_safe(access_safe),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_byte(cmd_byte), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_byte(rsp_byte));
  ehp_sva ehp_sva_inst (.ref_clk(ref_clk), .reset_n(reset_n), .p_bus(bus_if.p_bus), .p_host_out(bus_if.p_host_out),
    .p_host_oe(bus_if.p_host_oe), .p_dev_out(bus_if.p_dev_out), .p_dev_oe(bus_if.p_dev_oe), .cs_n(bus_if.cs_n),
    .rw(bus_if.rw), .ad(bus_if.ad), .host_port_select(bus_if.host_port_select), .dev_reset_n(bus_if.dev_reset_n));
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [183:0] got, input logic [183:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [119:0] dflt();
    logic [119:0] v;
    v = {15{`EHP_WT_OTHER_RST}};
    v[(`EHP_WT_CFG2_ADDR-1)*8+:8]  = `EHP_WT_CFG2_RST;
    v[(`EHP_WT_CFG3_ADDR-1)*8+:8]  = `EHP_WT_CFG3_RST;
    v[(`EHP_WT_SENS9_ADDR-1)*8+:8] = `EHP_WT_SENS9_RST;
    v[(`EHP_WT_CTL15_ADDR-1)*8+:8] = `EHP_WT_CTL15_RST;
    return v;
  endfunction : dflt
  function automatic ehp_video_t clip_of(ehp_video_t v, logic on);
    if (on && v < 10'h004)
      return 10'h004;
    if (on && v > 10'h3FB)
      return 10'h3FB;
    return v;
  endfunction : clip_of
  // ----------------------------------------
  // host command driver
  // ----------------------------------------
  task automatic cmd(input ehp_cmd_t k, input ehp_byte_t d);
    int n;
    n = 0;
    @(posedge ref_clk);
    cmd_valid   <= 1'b1;
    cmd_kind    <= k;
    cmd_byte    <= d;
    access_safe <= 1'b0;
    // one unsafe cycle first: request must wait, not go out
    @(posedge ref_clk);
    access_safe <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (!(cmd_ready === 1'b1 && access_safe === 1'b1) && n < 100);
    if (n >= 100)
      miscompares++;
    cmd_valid   <= 1'b0;
    access_safe <= 1'b0;
  endtask : cmd
  task automatic rd(input ehp_byte_t e);
    exp_q.push_back(e);
    cmd(EHP_CMD_RD, 8'h00);
  endtask : rd
  task automatic wait_ready();
    int n;
    for (n = 0; n < 200 && cmd_ready !== 1'b1; n++)
      @(posedge ref_clk);
  endtask : wait_ready
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // output watcher
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    video_in <= $urandom_range(1) ? 10'($urandom) : ($urandom_range(1) ? 10'($urandom_range(7)) : 10'h3FF - 10'($urandom_range(7)));
    vin_d   <= video_in;
    clip_d  <= config_bytes[CLIP_IDX];
    clip_dd <= clip_d;
    if (rsp_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        miscompares++;
        $display("ERROR %0t unexpected read data", $time);
      end
      else
        chk(rsp_byte, exp_q.pop_front());
    end
    // skip cycles where the clip bit is still settling
    if (vid_on && clip_dd === clip_d && clip_d === config_bytes[CLIP_IDX])
      chk(video_out, clip_of(vin_d, clip_d));
  end
  initial
  begin
    #80000;
    miscompares++;
    $display("ERROR %0t watchdog expired", $time);
    tally_and_finish();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'hE8A9F410));
    reset_n = 1'b0; access_safe = 1'b0; cmd_valid = 1'b0; cmd_kind = EHP_CMD_ADDR; cmd_byte = 8'h00;
    edh_pkt_exit = 1'b0; edh_pkt_insert = 1'b0; status_bytes = '0; video_in = 10'h000; vid_on = 1'b0;
    repeat (2) @(posedge ref_clk);
    vid_on <= 1'b1;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    wait_ready();
    chk(config_bytes, dflt());
    $display("test defaults done");
    for (int i = 0; i < 23; i++)
      snap[i*8+:8] = 8'($urandom);
    @(posedge ref_clk);
    status_bytes <= snap;
    edh_pkt_exit <= 1'b1;
    @(posedge ref_clk);
    edh_pkt_exit <= 1'b0;
    cmd(EHP_CMD_ADDR, 8'h01);
    for (int a = 1; a <= 24; a++)
      rd(a <= 23 ? snap[(a-1)*8+:8] : 8'h00);
    @(posedge ref_clk);
    status_bytes <= ~snap;
    cmd(EHP_CMD_ADDR, 8'h02);
    rd(snap[15:8]);
    $display("test read table done");
    exp_cfg = dflt();
    cmd(EHP_CMD_ADDR, 8'h01);
    for (int a = 1; a <= 15; a++)
    begin
      b = 8'($urandom);
      if (a == `EHP_WT_CFG3_ADDR)
        b[`EHP_CLIP_BIT] = 1'b1;
      exp_cfg[(a-1)*8+:8] = b;
      cmd(EHP_CMD_WR, b);
    end
    cmd(EHP_CMD_ADDR, 8'h09);
    cmd(EHP_CMD_WR, 8'h5A);
    cmd(EHP_CMD_ADDR, 8'h04);
    cmd(EHP_CMD_WR, 8'hA5);
    cmd(EHP_CMD_ADDR, 8'h00);
    cmd(EHP_CMD_WR, 8'h33);
    exp_cfg[71:64] = 8'h5A;
    exp_cfg[31:24] = 8'hA5;
    repeat (4) @(posedge ref_clk);
    chk(config_bytes, dflt());
    edh_pkt_insert <= 1'b1;
    @(posedge ref_clk);
    edh_pkt_insert <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(config_bytes, exp_cfg);
    repeat (60) @(posedge ref_clk);
    $display("test writes done");
    reset_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk(config_bytes, dflt());
    reset_n <= 1'b1;
    wait_ready();
    chk(config_bytes, dflt());
    repeat (4) @(posedge ref_clk);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule : edh_parallel_host_port_bench
`default_nettype wire
